// File: include/cdd_pkg.sv
// constants for the clock distribution and divider block
// assumes a 250 MHz sys_clk and word-wide ahb-lite register access
package cdd_pkg;
  localparam int CDD_NUM_PAIRS = 7;
  localparam int CDD_DCLK_W = 6;
  localparam int CDD_SREF_W = 13;
  localparam int CDD_RDIV_W = 8;
  localparam int CDD_DLY_W = 4;
  localparam logic [CDD_DCLK_W-1:0] CDD_DCLK_MIN = 6'h01;
  localparam logic [CDD_DCLK_W-1:0] CDD_DCLK_MAX = 6'h20;
  localparam logic [CDD_SREF_W-1:0] CDD_SREF_MIN = 13'h0008;
  localparam logic [CDD_SREF_W-1:0] CDD_SREF_MAX = 13'h1fff;
  // register byte offsets
  localparam logic [7:0] CDD_CTRL_OFS = 8'h00;
  localparam logic [7:0] CDD_RDIV_A_OFS = 8'h04;
  localparam logic [7:0] CDD_RDIV_B_OFS = 8'h08;
  localparam logic [7:0] CDD_RDIV_C_OFS = 8'h0c;
  localparam logic [7:0] CDD_SREF_DIV_OFS = 8'h10;
  localparam logic [7:0] CDD_STATUS_OFS = 8'h14;
  localparam logic [7:0] CDD_SYNC_OFS = 8'h18;
  localparam logic [7:0] CDD_DCLK_BASE_OFS = 8'h20;
  // control register fields
  localparam int CDD_MODE_LSB = 0;
  localparam int CDD_MSEL_LSB = 2;
  localparam int CDD_BUSE_LSB = 4;
  localparam int CDD_OSCEN_BIT = 6;
  localparam int CDD_VCOSEL_BIT = 7;
  localparam int CDD_BSRC_LSB = 8;
  localparam int CDD_DCC_BIT = 10;
  localparam int CDD_PD1_BIT = 11;
  localparam int CDD_PD2_BIT = 12;
  localparam logic [12:0] CDD_CTRL_RST = 13'h0440;
  // per-pair register fields
  localparam int CDD_PAIR_RATIO_LSB = 0;
  localparam int CDD_PAIR_ROUTE_BIT = 6;
  localparam int CDD_PAIR_PD_BIT = 7;
  localparam int CDD_PAIR_DLY_LSB = 8;
  localparam logic [CDD_RDIV_W-1:0] CDD_RDIV_RST = 8'h01;
  localparam logic [CDD_SREF_W-1:0] CDD_SREF_RST = 13'h0100;
  localparam logic [CDD_DCLK_W-1:0] CDD_DCLK_RST = 6'h02;
  // loss-of-signal timeout
  localparam int CDD_CLK_MHZ = 250;
  localparam int CDD_LOS_NS = 1000;
  localparam int CDD_LOS_CYC = CDD_LOS_NS * CDD_CLK_MHZ / 1000;
  localparam int CDD_LOS_W = 10;
  typedef enum logic [1:0] {CDD_SEL_MANUAL, CDD_SEL_PINS, CDD_SEL_AUTO,
    CDD_SEL_RSVD} cdd_mode_t;
  typedef enum logic [1:0] {CDD_BUSE_REF, CDD_BUSE_FEEDBACK, CDD_BUSE_EXTVCO,
    CDD_BUSE_RSVD} cdd_buse_t;
  typedef enum logic [1:0] {CDD_SRC_OSC, CDD_SRC_DCLK6, CDD_SRC_DCLK8,
    CDD_SRC_SYSREF} cdd_bsrc_t;
endpackage : cdd_pkg

// File: design/cdd_top.sv
// clock selection, reference dividers, device and sysref dividers
// assumes sys_clk is the selected distribution clock; pins are async
//
// Overview of operation
// - each device clock pair has its own divider, ratio 1 to 32
// - duty cycle correction gives a half-period high time, rounded up for odd ratios
// - device divider X may drive the paired sysref-capable output X+1
// - sysref-capable outputs not routed to a device divider share one sysref divider
// - shared sysref divider accepts any ratio from 8 to 8191
// - seven device clocks paired with seven sysref clocks
// - sysref-capable outputs may be turned into extra device clocks
// - first-loop reference picked from three inputs, manual or automatic
// - each reference input has its own reference divider
// - in pin mode the two select pins choose the active reference
// - reference b may serve as feedback or external vco input instead
// - reference c pins shared with buffered output, one use at a time
// - after reset the buffered output copies the oscillator input
// - buffered output source: oscillator, device clock 6, 8 or sysref
// - selector picks one of two vcos for distribution and feedback
// - external vco use removes reference b from availability
// - with no valid reference and pll1 up the block holds over until the selected one, or in auto mode any one, returns
// - single loop and distribution modes come from power-down bits
// - new digital delay values apply only at a sync event
`timescale 1ns/10ps

module cdd_div #(
  parameter int W = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic step,
  input wire logic run,
  input wire logic dcc,
  input wire logic load,
  input wire logic [W-1:0] ratio,
  input wire logic [W-1:0] start,
  output logic clk_out
);
  logic [W-1:0] cnt;
  logic [W-1:0] cur;
  wire wrap = (cnt >= cur - 1'b1);
  wire [W-1:0] next_cnt = load ? start : (wrap ? '0 : cnt + 1'b1);
  wire [W-1:0] next_cur = (load || wrap) ? ratio : cur;
  // high time is half the period, rounded up, when correcting duty
  wire [W:0] next_hi = dcc ? ({1'b0, next_cur} + 1'b1) >> 1 : {{W{1'b0}}, 1'b1};
  wire next_out = run && ({1'b0, next_cnt} < next_hi);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      cur <= {{(W-1){1'b0}}, 1'b1};
      clk_out <= 1'b0;
    end else if (load || (step && run)) begin
      cnt <= next_cnt;
      cur <= next_cur;
      clk_out <= next_out;
    end else if (!run) begin
      clk_out <= 1'b0;
    end
  end
endmodule : cdd_div

module cdd_top
  import cdd_pkg::*;
#(
  parameter int NUM_PAIRS = cdd_pkg::CDD_NUM_PAIRS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reference_input_a,
  input wire logic reference_input_b,
  input wire logic reference_input_c,
  input wire logic ref_select_pin_a,
  input wire logic ref_select_pin_b,
  input wire logic oscillator_reference_input,
  input wire logic sync_pin,
  output logic buffered_oscillator_output,
  output logic buffered_oscillator_output_oe,
  output logic [NUM_PAIRS-1:0] device_clock_output,
  output logic [NUM_PAIRS-1:0] sysref_capable_output,
  output logic pll1_reference,
  output logic [1:0] active_reference,
  output logic holdover,
  output logic oscillator_selector,
  output logic external_feedback_input,
  output logic external_vco_enable,
  output logic pll1_power_down,
  output logic pll2_power_down
);
  import cdd_pkg::*;

  localparam logic [CDD_LOS_W-1:0] LOS_LIMIT = CDD_LOS_W'(CDD_LOS_CYC);

  // control and divider settings
  logic [12:0] ctrl;
  logic [CDD_RDIV_W-1:0] rdiv [3];
  logic [CDD_SREF_W-1:0] sref_div;
  logic [CDD_DCLK_W-1:0] pair_ratio [NUM_PAIRS];
  logic [NUM_PAIRS-1:0] pair_route;
  logic [NUM_PAIRS-1:0] pair_pd;
  logic [CDD_DLY_W-1:0] pair_dly [NUM_PAIRS];
  logic sw_sync;

  // bus pipeline
  logic wr_pend;
  logic [7:0] wr_addr;

  // pin synchronisers
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [3:0] pin_d;
  logic [2:0] rf_age_ok;
  logic [CDD_LOS_W-1:0] los_cnt [3];
  logic [1:0] sel;
  logic [2:0] rdiv_out;
  logic [NUM_PAIRS-1:0] dclk_raw;
  logic sref_raw;

  wire [2:0] ref_pin = pin_s2[2:0];
  wire [1:0] sel_pins = pin_s2[4:3];
  wire osc_s = pin_s2[5];
  wire sync_s = pin_s2[6];
  wire [2:0] ref_edge = ref_pin & ~pin_d[2:0];
  wire sync_evt = (sync_s & ~pin_d[3]) | sw_sync;

  wire cdd_mode_t mode = cdd_mode_t'(ctrl[CDD_MODE_LSB +: 2]);
  wire cdd_buse_t buse = cdd_buse_t'(ctrl[CDD_BUSE_LSB +: 2]);
  wire cdd_bsrc_t bsrc = cdd_bsrc_t'(ctrl[CDD_BSRC_LSB +: 2]);
  wire osc_out_en = ctrl[CDD_OSCEN_BIT];
  wire dcc_en = ctrl[CDD_DCC_BIT];
  wire pd1 = ctrl[CDD_PD1_BIT];
  wire pd2 = ctrl[CDD_PD2_BIT];

  // reference b lost to feedback or external vco, c lost to buffered output
  wire [2:0] avail = {~osc_out_en, buse == CDD_BUSE_REF, 1'b1};
  wire [2:0] usable = avail & rf_age_ok;

  // bus decode
  wire bus_take = hsel && htrans[1] && hready;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_hi_zero = (haddr[31:8] == 24'h000000);
  wire a_pair = a_hi_zero && (a_ofs >= CDD_DCLK_BASE_OFS) &&
    (a_ofs < CDD_DCLK_BASE_OFS + 8'(4 * NUM_PAIRS));
  wire [7:0] a_pidx = (a_ofs - CDD_DCLK_BASE_OFS) >> 2;
  wire [7:0] w_pidx = (wr_addr - CDD_DCLK_BASE_OFS) >> 2;
  wire w_pair = (wr_addr >= CDD_DCLK_BASE_OFS) &&
    (wr_addr < CDD_DCLK_BASE_OFS + 8'(4 * NUM_PAIRS));
  wire [CDD_DCLK_W-1:0] w_dclk = hwdata[CDD_DCLK_W-1:0];
  wire [CDD_SREF_W-1:0] w_sref = hwdata[CDD_SREF_W-1:0];
  // ratios outside the legal range clamp to the nearest end
  wire [CDD_DCLK_W-1:0] w_dclk_c = (w_dclk < CDD_DCLK_MIN) ? CDD_DCLK_MIN :
    ((w_dclk > CDD_DCLK_MAX) ? CDD_DCLK_MAX : w_dclk);
  wire [CDD_SREF_W-1:0] w_sref_c = (w_sref < CDD_SREF_MIN) ? CDD_SREF_MIN :
    w_sref;
  wire [CDD_RDIV_W-1:0] w_rdiv = (hwdata[CDD_RDIV_W-1:0] == '0) ?
    CDD_RDIV_RST : hwdata[CDD_RDIV_W-1:0];

  wire [31:0] status_word = {24'h000000, 1'b0, usable, 1'b0, holdover,
    active_reference};
  wire [31:0] pair_word = a_pair ? {16'h0000, 4'h0, pair_dly[a_pidx[2:0]],
    pair_pd[a_pidx[2:0]], pair_route[a_pidx[2:0]],
    pair_ratio[a_pidx[2:0]]} : 32'h00000000;
  wire [31:0] rd_word =
    (!a_hi_zero) ? 32'h00000000 :
    (a_ofs == CDD_CTRL_OFS) ? {19'h00000, ctrl} :
    (a_ofs == CDD_RDIV_A_OFS) ? {24'h000000, rdiv[0]} :
    (a_ofs == CDD_RDIV_B_OFS) ? {24'h000000, rdiv[1]} :
    (a_ofs == CDD_RDIV_C_OFS) ? {24'h000000, rdiv[2]} :
    (a_ofs == CDD_SREF_DIV_OFS) ? {19'h00000, sref_div} :
    (a_ofs == CDD_STATUS_OFS) ? status_word : pair_word;

  // reference selection
  logic [1:0] next_sel;
  always_comb begin
    next_sel = sel;
    case (mode)
      CDD_SEL_MANUAL: next_sel = ctrl[CDD_MSEL_LSB +: 2];
      CDD_SEL_PINS: next_sel = sel_pins;
      CDD_SEL_AUTO: begin
        if (sel > 2'h2 || !usable[sel]) begin
          if (usable[0]) begin
            next_sel = 2'h0;
          end else if (usable[1]) begin
            next_sel = 2'h1;
          end else if (usable[2]) begin
            next_sel = 2'h2;
          end
        end
      end
      default: next_sel = sel;
    endcase
  end
  wire sel_ok = (next_sel <= 2'h2) && usable[next_sel];

  // register writes land in the data phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= bus_take && hwrite && a_hi_zero;
      wr_addr <= a_ofs;
      if (bus_take && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= CDD_CTRL_RST;
      sref_div <= CDD_SREF_RST;
      sw_sync <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        rdiv[i] <= CDD_RDIV_RST;
      end
    end else begin
      sw_sync <= wr_pend && (wr_addr == CDD_SYNC_OFS) && hwdata[0];
      if (wr_pend && wr_addr == CDD_CTRL_OFS) begin
        ctrl <= hwdata[12:0];
      end
      if (wr_pend && wr_addr == CDD_SREF_DIV_OFS) begin
        sref_div <= w_sref_c;
      end
      if (wr_pend && wr_addr == CDD_RDIV_A_OFS) begin
        rdiv[0] <= w_rdiv;
      end
      if (wr_pend && wr_addr == CDD_RDIV_B_OFS) begin
        rdiv[1] <= w_rdiv;
      end
      if (wr_pend && wr_addr == CDD_RDIV_C_OFS) begin
        rdiv[2] <= w_rdiv;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        pair_ratio[i] <= CDD_DCLK_RST;
        pair_dly[i] <= '0;
      end
      pair_route <= '0;
      pair_pd <= '0;
    end else if (wr_pend && w_pair) begin
      pair_ratio[w_pidx[2:0]] <= w_dclk_c;
      pair_route[w_pidx[2:0]] <= hwdata[CDD_PAIR_ROUTE_BIT];
      pair_pd[w_pidx[2:0]] <= hwdata[CDD_PAIR_PD_BIT];
      pair_dly[w_pidx[2:0]] <= hwdata[CDD_PAIR_DLY_LSB +: CDD_DLY_W];
    end
  end

  // two-flop synchronisers; the second stage alone feeds logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= {sync_pin, oscillator_reference_input, ref_select_pin_b,
        ref_select_pin_a, reference_input_c, reference_input_b,
        reference_input_a};
      pin_s2 <= pin_s1;
      pin_d <= {sync_s, ref_pin};
    end
  end

  // loss of signal: no rising edge within the timeout marks a reference bad
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        los_cnt[i] <= '0;
      end
      rf_age_ok <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ref_edge[i]) begin
          los_cnt[i] <= '0;
          rf_age_ok[i] <= 1'b1;
        end else if (los_cnt[i] < LOS_LIMIT) begin
          los_cnt[i] <= los_cnt[i] + 1'b1;
        end else begin
          rf_age_ok[i] <= 1'b0;
        end
      end
    end
  end

  // active reference and holdover
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel <= 2'h0;
      active_reference <= 2'h0;
      holdover <= 1'b1;
      pll1_reference <= 1'b0;
    end else begin
      sel <= next_sel;
      active_reference <= next_sel;
      holdover <= !pd1 && !sel_ok;
      pll1_reference <= sel_ok && !pd1 && rdiv_out[next_sel];
    end
  end

  // one reference divider per input, stepped by that input's edges
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rdiv
      cdd_div #(.W(CDD_RDIV_W)) u_rdiv (
        .sys_clk(sys_clk),
        .rst(rst),
        .step(ref_edge[g]),
        .run(!pd1 && avail[g]),
        .dcc(1'b1),
        .load(1'b0),
        .ratio(rdiv[g]),
        .start('0),
        .clk_out(rdiv_out[g])
      );
    end
    for (g = 0; g < NUM_PAIRS; g++) begin : g_dclk
      cdd_div #(.W(CDD_DCLK_W)) u_dclk (
        .sys_clk(sys_clk),
        .rst(rst),
        .step(1'b1),
        .run(!pair_pd[g] && !pd2),
        .dcc(dcc_en),
        .load(sync_evt),
        .ratio(pair_ratio[g]),
        .start(CDD_DCLK_W'(pair_dly[g])),
        .clk_out(dclk_raw[g])
      );
    end
  endgenerate

  cdd_div #(.W(CDD_SREF_W)) u_sref (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(1'b1),
    .run(!pd2),
    .dcc(1'b1),
    .load(sync_evt),
    .ratio(sref_div),
    .start('0),
    .clk_out(sref_raw)
  );

  // output stage
  logic next_buf;
  always_comb begin
    case (bsrc)
      CDD_SRC_OSC: next_buf = osc_s;
      CDD_SRC_DCLK6: next_buf = dclk_raw[3];
      CDD_SRC_DCLK8: next_buf = dclk_raw[4];
      CDD_SRC_SYSREF: next_buf = sref_raw;
      default: next_buf = osc_s;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      device_clock_output <= '0;
      sysref_capable_output <= '0;
      buffered_oscillator_output <= 1'b0;
      buffered_oscillator_output_oe <= 1'b1;
      oscillator_selector <= 1'b0;
      external_feedback_input <= 1'b0;
      external_vco_enable <= 1'b0;
      pll1_power_down <= 1'b0;
      pll2_power_down <= 1'b0;
    end else begin
      device_clock_output <= dclk_raw;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        sysref_capable_output[i] <= pair_route[i] ? dclk_raw[i] :
          sref_raw;
      end
      buffered_oscillator_output <= osc_out_en && next_buf;
      buffered_oscillator_output_oe <= osc_out_en;
      oscillator_selector <= ctrl[CDD_VCOSEL_BIT];
      external_feedback_input <= (buse == CDD_BUSE_FEEDBACK);
      external_vco_enable <= (buse == CDD_BUSE_EXTVCO);
      pll1_power_down <= pd1;
      pll2_power_down <= pd2;
    end
  end
endmodule : cdd_top

// File: tb/cdd_top_assertions.sv
// checker of the clock distribution block, bound to its top ports
// assumes whole-word writes and the control layout of cdd_pkg
`timescale 1ns/10ps
module cdd_top_checker
  import cdd_pkg::*;
#(
  parameter int NUM_PAIRS = CDD_NUM_PAIRS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reference_input_a,
  input wire logic reference_input_b,
  input wire logic reference_input_c,
  input wire logic ref_select_pin_a,
  input wire logic ref_select_pin_b,
  input wire logic oscillator_reference_input,
  input wire logic buffered_oscillator_output,
  input wire logic buffered_oscillator_output_oe,
  input wire logic [1:0] active_reference,
  input wire logic holdover,
  input wire logic oscillator_selector,
  input wire logic external_feedback_input,
  input wire logic external_vco_enable,
  input wire logic pll1_power_down,
  input wire logic pll2_power_down
);
  logic [12:0] c;
  logic wp;
  logic [9:0] q;
  logic [2:0] refs;
  logic [1:0] pins;
  assign refs = {reference_input_a, reference_input_b, reference_input_c};
  assign pins = {ref_select_pin_b, ref_select_pin_a};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of the control word and cycles since any reference moved
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      c <= CDD_CTRL_RST;
      wp <= 1'b0;
      q <= 10'h000;
    end else begin
      wp <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
      if (wp) begin
        c <= hwdata[12:0];
      end
      if (!$stable(refs)) begin
        q <= 10'h000;
      end else if (q != 10'h3ff) begin
        q <= q + 10'h001;
      end
    end
  end
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not ready or not okay");
  property p_vco; oscillator_selector == $past(c[7]); endproperty
  a_vco: assert property (p_vco)
    else $error("vco choice does not follow control");
  property p_pd; {pll2_power_down, pll1_power_down} == $past(c[12:11]);
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down outputs do not follow control");
  property p_bref;
    external_vco_enable == ($past(c[5:4]) == 2'h2) &&
      external_feedback_input == ($past(c[5:4]) == 2'h1);
  endproperty
  a_bref: assert property (p_bref)
    else $error("reference b use decode wrong");
  property p_oe; buffered_oscillator_output_oe == $past(c[6]); endproperty
  a_oe: assert property (p_oe)
    else $error("buffered output enable does not follow control");
  property p_copy;
    (c[9:8] == 2'h0 && c[6]) [*4] |->
      buffered_oscillator_output == $past(oscillator_reference_input, 3);
  endproperty
  a_copy: assert property (p_copy)
    else $error("buffered output is not the oscillator copy");
  property p_pins;
    (c[1:0] == 2'h1 && $stable(pins)) [*4] ##0 pins != 2'h3 |->
      active_reference == pins;
  endproperty
  a_pins: assert property (p_pins)
    else $error("active reference ignores select pins");
  property p_hold; q >= 10'h106 |-> holdover || pll1_power_down; endproperty
  a_hold: assert property (p_hold)
    else $error("no holdover with every reference quiet");
endmodule : cdd_top_checker

// File: tb/cdd_ref_src.sv
// reference and oscillator sources on the far side of the block
// assumes the bench starts and stops each reference through en
`timescale 1ns/10ps
module cdd_ref_src (
  input wire logic [2:0] en,
  output logic reference_input_a,
  output logic reference_input_b,
  output logic reference_input_c,
  output logic oscillator_reference_input
);
  // odd-nanosecond toggles keep every source off the sys_clk edges
  initial begin
    {reference_input_a, reference_input_b, reference_input_c} = 3'h0;
    oscillator_reference_input = 1'b0;
    #1;
    fork
      forever #16 oscillator_reference_input = !oscillator_reference_input;
      // a stopped source parks low, as a lost reference would
      forever #10 reference_input_a = en[0] && !reference_input_a;
      forever #14 reference_input_b = en[1] && !reference_input_b;
      forever #18 reference_input_c = en[2] && !reference_input_c;
    join
  end
endmodule : cdd_ref_src

// File: tb/test_clock_distribution_dividers.sv
// self-checking bench for the clock distribution block
// assumes cdd_ref_src models the reference and oscillator sources
`timescale 1ns/10ps
module test_clock_distribution_dividers;
  import cdd_pkg::*;
  logic sys_clk, rst, hsel, hwrite, sync_pin, hready, hreadyout, hresp;
  logic ref_select_pin_a, ref_select_pin_b, holdover, pll1_reference;
  logic [31:0] haddr, hwdata, hrdata, got;
  logic [1:0] htrans, active_reference;
  logic [2:0] hsize, en;
  logic reference_input_a, reference_input_b, reference_input_c;
  logic oscillator_reference_input, oscillator_selector;
  logic buffered_oscillator_output, buffered_oscillator_output_oe;
  logic external_feedback_input, external_vco_enable;
  logic pll1_power_down, pll2_power_down;
  logic [6:0] device_clock_output, sysref_capable_output;
  logic [16:0] taps;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int failures, comparisons, cyc;
  int be [4] = '{8, 16, 4, 2};
  event res_ev;
  assign hready = hreadyout;
  assign taps = {pll1_reference, buffered_oscillator_output,
    sysref_capable_output,
    device_clock_output[0] ^ device_clock_output[1], device_clock_output};
  cdd_ref_src src (.en, .reference_input_a, .reference_input_b,
    .reference_input_c, .oscillator_reference_input);
  cdd_top dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .reference_input_a,
    .reference_input_b, .reference_input_c, .ref_select_pin_a,
    .ref_select_pin_b, .oscillator_reference_input, .sync_pin,
    .buffered_oscillator_output, .buffered_oscillator_output_oe,
    .device_clock_output, .sysref_capable_output, .pll1_reference,
    .active_reference, .holdover, .oscillator_selector,
    .external_feedback_input, .external_vco_enable, .pll1_power_down,
    .pll2_power_down);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = !sys_clk;
  end
  task automatic end_sim;
    $display("counts: %0d compared, %0d wrong", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [31:0] s, w);
    comparisons++;
    if (s !== w) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, w, s);
    end
  endtask : check
  always @(res_ev) begin
    check(nm_q.pop_front(), got, exp_q.pop_front());
  end
  task automatic res(input string nm, input logic [31:0] s, w);
    nm_q.push_back(nm);
    exp_q.push_back(w);
    got = s;
    -> res_ev;
    @(posedge sys_clk);
  endtask : res
  task automatic bus(input logic wr, input logic [31:0] a, d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, {24'h0, a}, d, r);
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a,
    input logic [31:0] w);
    logic [31:0] r;
    bus(1'b0, {24'h0, a}, 32'h0, r);
    res(nm, r, w);
  endtask : rd
  task automatic meas(input int b, n, output logic [31:0] hi, ed);
    logic p;
    hi = 32'h0;
    ed = 32'h0;
    p = taps[b];
    repeat (n) begin
      @(posedge sys_clk);
      hi += 32'(taps[b]);
      ed += 32'(taps[b] && !p);
      p = taps[b];
    end
  endtask : meas
  task automatic sync_ev;
    sync_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sync_pin <= 1'b0;
    repeat (30) @(posedge sys_clk);
  endtask : sync_ev
  initial begin
    logic [31:0] hi, ed, r, w;
    int n;
    {hsel, hwrite, sync_pin, ref_select_pin_a, ref_select_pin_b} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    en = 3'h7;
    rst = 1'b1;
    void'($urandom(32'h80fd));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd("ctrl", CDD_CTRL_OFS, {19'h0, CDD_CTRL_RST});
    rd("rdiv b", CDD_RDIV_B_OFS, {24'h0, CDD_RDIV_RST});
    rd("sref div", CDD_SREF_DIV_OFS, {19'h0, CDD_SREF_RST});
    rd("pair 6", 8'h38, {26'h0, CDD_DCLK_RST});
    rd("unmapped", 8'h1c, 32'h0);
    bus(1'b0, 32'h100, 32'h0, r);
    res("high addr", r, 32'h0);
    $display("done: reset values");
    wr(CDD_DCLK_BASE_OFS, 32'h0);
    rd("ratio 0", CDD_DCLK_BASE_OFS, 32'h1);
    wr(CDD_DCLK_BASE_OFS, 32'h21);
    rd("ratio 33", CDD_DCLK_BASE_OFS, 32'h20);
    wr(CDD_SREF_DIV_OFS, 32'h1fff);
    rd("sref max", CDD_SREF_DIV_OFS, 32'h1fff);
    wr(CDD_SREF_DIV_OFS, 32'h7);
    rd("sref 7", CDD_SREF_DIV_OFS, 32'h8);
    sync_ev();
    meas(8, 80, hi, ed);
    res("sref 0 edges", ed, 32'd10);
    meas(13, 80, hi, ed);
    res("sref 5 edges", ed, 32'd10);
    $display("done: ratio limits");
    for (int i = 0; i < 6; i++) begin
      n = (i < 2) ? 1 + 31 * i : 1 + $urandom % 32;
      wr(CDD_CTRL_OFS, {21'h0, i[0], 10'h040});
      wr(8'h28, 32'h40 | 32'(n));
      repeat (70) @(posedge sys_clk);
      w = i[0] ? 32'(4 * ((n + 1) / 2)) : 32'd4;
      meas(2, 4 * n, hi, ed);
      res("dclk high", hi, w);
      meas(10, 4 * n, hi, ed);
      res("routed high", hi, w);
    end
    $display("done: device dividers");
    wr(CDD_CTRL_OFS, 32'h440);
    wr(CDD_DCLK_BASE_OFS, 32'h008);
    wr(8'h24, 32'h408);
    sync_ev();
    meas(7, 32, hi, ed);
    res("delayed skew", hi, 32'd32);
    wr(8'h24, 32'h008);
    repeat (20) @(posedge sys_clk);
    meas(7, 32, hi, ed);
    res("delay held", hi, 32'd32);
    wr(CDD_SYNC_OFS, 32'h1);
    repeat (20) @(posedge sys_clk);
    meas(7, 32, hi, ed);
    res("soft sync", hi, 32'd0);
    $display("done: sync delay");
    wr(8'h2c, 32'h4);
    wr(8'h30, 32'h10);
    wr(CDD_SREF_DIV_OFS, 32'h20);
    sync_ev();
    for (int s = 0; s < 4; s++) begin
      wr(CDD_CTRL_OFS, {22'h0, s[1:0], 8'h40});
      repeat (20) @(posedge sys_clk);
      meas(15, 64, hi, ed);
      res("buffered edges", ed, 32'(be[s]));
    end
    $display("done: buffered output");
    wr(CDD_CTRL_OFS, 32'h041);
    for (int p = 1; p >= 0; p--) begin
      {ref_select_pin_b, ref_select_pin_a} <= p[1:0];
      repeat (8) @(posedge sys_clk);
      res("pin select", {30'h0, active_reference}, 32'(p));
    end
    for (int s = 0; s < 3; s++) begin
      wr(CDD_CTRL_OFS, 32'h1080 | 32'(s << 2));
      repeat (8) @(posedge sys_clk);
      rd("manual", CDD_STATUS_OFS, 32'h70 | 32'(s));
    end
    wr(CDD_RDIV_A_OFS, 32'h2);
    wr(CDD_CTRL_OFS, 32'h1080);
    repeat (20) @(posedge sys_clk);
    meas(16, 100, hi, ed);
    res("ref div a", ed, 32'd10);
    wr(CDD_CTRL_OFS, 32'h042);
    en <= 3'h6;
    repeat (300) @(posedge sys_clk);
    res("auto", {29'h0, holdover, active_reference}, 32'h1);
    en <= 3'h4;
    repeat (300) @(posedge sys_clk);
    res("only c", {31'h0, holdover}, 32'h1);
    en <= 3'h7;
    repeat (20) @(posedge sys_clk);
    res("ref back", {31'h0, holdover}, 32'h0);
    wr(CDD_CTRL_OFS, 32'h062);
    en <= 3'h2;
    repeat (300) @(posedge sys_clk);
    res("ext vco", {31'h0, holdover}, 32'h1);
    en <= 3'h0;
    repeat (300) @(posedge sys_clk);
    wr(CDD_CTRL_OFS, 32'h800);
    repeat (8) @(posedge sys_clk);
    res("pll1 down", {31'h0, holdover}, 32'h0);
    en <= 3'h7;
    repeat (20) @(posedge sys_clk);
    $display("done: reference selection");
    end_sim();
  end
endmodule : test_clock_distribution_dividers
bind cdd_top cdd_top_checker #(.NUM_PAIRS(NUM_PAIRS)) chk (.sys_clk, .rst,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .reference_input_a, .reference_input_b, .reference_input_c,
  .ref_select_pin_a, .ref_select_pin_b, .oscillator_reference_input,
  .buffered_oscillator_output, .buffered_oscillator_output_oe,
  .active_reference, .holdover, .oscillator_selector,
  .external_feedback_input, .external_vco_enable, .pll1_power_down,
  .pll2_power_down);
